// [stm_cfg.svh]
// Register offsets, field positions, widths and reset values for the timer block
`ifndef STM_CFG_SVH
`define STM_CFG_SVH

// Register byte offsets
`define OFF_CTRL      12'h000
`define OFF_CMPA      12'h004
`define OFF_PERIOD    12'h008
`define OFF_COUNT     12'h00C
`define OFF_STATUS    12'h010

// Control register field positions
`define CTRL_RUN      0
`define CTRL_MODE_LO  1
`define CTRL_MODE_HI  2
`define CTRL_PF_LO    3
`define CTRL_PF_HI    4
`define CTRL_INIT     5
`define CTRL_INV      6
`define CTRL_CLR_SRC  7
`define CTRL_SWAP     8
`define CTRL_PIN_SEL  9
`define CTRL_TRIG_EDG 10

// Status register field positions
`define STAT_CMPA     0
`define STAT_PERIOD   1
`define STAT_CAPTURE  2

// Widths and reset values
`define CNT_W         10
`define PER_W         3
`define CTRL_RST      32'h0000_0000
`define CMPA_RST      10'h000
`define PER_RST       3'h0

`endif

// [stm_pkg.sv]
// Types shared by the timer block
package stm_pkg;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PULSE   = 2'h2,
    MODE_TIMER   = 2'h3
  } tmode_t;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_OFF  = 2'h3
  } edge_sel_t;

  typedef struct packed {
    logic        trig_edge;   // 0 rising, 1 falling trigger
    logic        pin_sel;
    logic        swap;
    logic        clr_src;
    logic        invert;
    logic        init_level;
    logic [1:0]  pin_func;
    tmode_t      mode;
  } ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// [stm_edge_det.sv]
// Edge detector for a synchronous pin input with selectable edge
`timescale 1ns/1ps
`default_nettype none
module stm_edge_det
  import stm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Pin and selection
  input  wire logic       pin,
  input  wire edge_sel_t  sel,
  // Result
  output logic            hit
);
  logic pin_q;

  // Previous pin level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end

  // Edge decode by selection
  always_comb begin
    case (sel)
      EDGE_RISE: hit = pin & ~pin_q;
      EDGE_FALL: hit = ~pin & pin_q;
      EDGE_BOTH: hit = pin ^ pin_q;
      default:   hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [stm_timer.sv]
// Single-pulse and capture timer with APB register access
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "stm_cfg.svh"

// Notes on behaviour
// - Run bit rising edge starts pulse
// - Trigger pin edge sets run bit
// - Run rise starts counter and drives pulse
// - Run bit clear ends the pulse
// - Compare A match clears run bit
// - Compare A match raises interrupt in pulse
// - Pulse counter zeroed only on run rise
// - Pulse mode ignores period, clear, swap
// - Capture counter starts on run rise
// - Capture edge copies counter into compare A
// - Capture counter free runs until run falls
// - Period match zeroes counter and raises interrupt
// - Period zero counts to full maximum
// - Pin function 11 disables capture and is required for pulse mode
// - Capture pin sensed even when output
// - Capture mode has no pin output
// - Edge code: rise, fall, both, off
// - Run rise zeroes; run fall holds count
// - Period match needs top counter bits equal to period and low bits zero
module stm_timer
  import stm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        ext_trigger_pin,
  input  wire logic        capture_pin_zero,
  input  wire logic        capture_pin_one,
  output logic             pulse_out,
  output logic             pulse_oe,
  // Event strobe
  output logic             timer_irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Bus request, control fields and timer state
  apb_req_t               req;
  ctrl_t                  ctrl_q;
  logic                   counter_run_bit;
  logic                   run_prev_q;
  logic [`CNT_W-1:0]      count_q;
  logic [`CNT_W-1:0]      compare_a_value;
  logic [`PER_W-1:0]      period_compare_value;
  logic [2:0]             stat_q;
  logic                   out_q;
  logic                   trig_q;
  logic                   irq_q;

  // Decoded strobes, matches and edges
  logic                   wr_en;
  logic                   rd_en;
  logic                   mapped;
  logic                   run_rise;
  logic                   run_fall;
  logic                   pulse_mode;
  logic                   capt_mode;
  logic                   match_a;
  logic                   match_p;
  logic                   trig_hit;
  logic                   cap_pin;
  logic                   cap_hit;
  logic                   run_wr_val;

  // Compares top counter bits with period value; zero never matches
  function automatic logic period_hit(input logic [`CNT_W-1:0] cnt,
                                      input logic [`PER_W-1:0] per);
    period_hit = (per != `PER_RST) &&
                 (cnt == {per, {(`CNT_W-`PER_W){1'b0}}});
  endfunction

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero-wait slave; error only on an unmapped access
  assign req     = '{psel: psel, penable: penable, pwrite: pwrite,
                     paddr: paddr, pwdata: pwdata};
  assign pready  = 1'b1;
  assign mapped  = addr_is(req.paddr, `OFF_CTRL) | addr_is(req.paddr, `OFF_CMPA) |
                   addr_is(req.paddr, `OFF_PERIOD) | addr_is(req.paddr, `OFF_COUNT) |
                   addr_is(req.paddr, `OFF_STATUS);
  assign pslverr = req.psel & req.penable & ~mapped;
  assign wr_en   = req.psel & req.penable & req.pwrite & mapped;
  assign rd_en   = req.psel & ~req.penable & ~req.pwrite;
  assign run_wr_val = req.pwdata[`CTRL_RUN];

  // Read data registered in the setup cycle, valid in access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (req.paddr)
        `OFF_CTRL:   prdata <= {21'h00_0000, ctrl_q, counter_run_bit};
        `OFF_CMPA:   prdata <= {22'h00_0000, compare_a_value};
        `OFF_PERIOD: prdata <= {29'h000_0000, period_compare_value};
        `OFF_COUNT:  prdata <= {22'h00_0000, count_q};
        `OFF_STATUS: prdata <= {29'h000_0000, stat_q};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control fields other than the run bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= ctrl_t'(10'(`CTRL_RST >> `CTRL_MODE_LO));
    end else if (wr_en && addr_is(req.paddr, `OFF_CTRL)) begin
      ctrl_q <= ctrl_t'(req.pwdata[`CTRL_TRIG_EDG:`CTRL_MODE_LO]);
    end
  end

  // Period value register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_compare_value <= `PER_RST;
    end else if (wr_en && addr_is(req.paddr, `OFF_PERIOD)) begin
      period_compare_value <= req.pwdata[`PER_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and match
  // ----------------------------------------------------------------
  // Mode select, compare matches, run edges and capture pin choice
  assign pulse_mode = (ctrl_q.mode == MODE_PULSE) && (ctrl_q.pin_func == 2'h3);
  assign capt_mode  = (ctrl_q.mode == MODE_CAPTURE);
  assign match_a    = counter_run_bit && (count_q == compare_a_value);
  assign match_p    = counter_run_bit && period_hit(count_q, period_compare_value);
  assign run_rise   = counter_run_bit & ~run_prev_q;
  assign run_fall   = ~counter_run_bit & run_prev_q;
  assign cap_pin    = ctrl_q.pin_sel ? capture_pin_one : capture_pin_zero;

  // Trigger pin edge detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= ext_trigger_pin;
    end
  end
  assign trig_hit = ctrl_q.trig_edge ? (trig_q & ~ext_trigger_pin)
                                     : (~trig_q & ext_trigger_pin);

  // Capture edge detector on selected pin, sensed regardless of direction
  stm_edge_det u_cap_edge (
    .clk    (clk),
    .resetn (resetn),
    .pin    (cap_pin),
    .sel    (edge_sel_t'(ctrl_q.pin_func)),
    .hit    (cap_hit)
  );

  // ----------------------------------------------------------------
  // Run bit
  // ----------------------------------------------------------------
  // Software write, trigger pin set and compare A clear; hardware clear wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      counter_run_bit <= 1'b0;
    end else if (pulse_mode && match_a && !run_rise) begin
      counter_run_bit <= 1'b0;
    end else if (pulse_mode && trig_hit && !counter_run_bit) begin
      counter_run_bit <= 1'b1;
    end else if (wr_en && addr_is(req.paddr, `OFF_CTRL)) begin
      counter_run_bit <= run_wr_val;
    end
  end

  // Previous run level, for rise and fall detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= counter_run_bit;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Zero on run rise, hold while stopped, period wrap only in capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (run_rise) begin
      count_q <= '0;
    end else if (!counter_run_bit) begin
      count_q <= count_q;
    end else if (capt_mode && match_p) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  // Compare A: software write, or capture of count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compare_a_value <= `CMPA_RST;
    end else if (capt_mode && counter_run_bit && cap_hit) begin
      compare_a_value <= count_q;
    end else if (wr_en && addr_is(req.paddr, `OFF_CMPA)) begin
      compare_a_value <= req.pwdata[`CNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Events and status
  // ----------------------------------------------------------------
  // Event strobes
  logic ev_a;
  logic ev_p;
  logic ev_c;
  assign ev_a = pulse_mode && match_a && !run_rise;
  assign ev_p = capt_mode && match_p;
  assign ev_c = capt_mode && counter_run_bit && cap_hit;

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~((wr_en && addr_is(req.paddr, `OFF_STATUS)) ?
                            req.pwdata[2:0] : 3'h0)) | {ev_c, ev_p, ev_a};
    end
  end

  // One-cycle request pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ev_a | ev_p | ev_c;
    end
  end
  assign timer_irq = irq_q;

  // ----------------------------------------------------------------
  // Pulse output
  // ----------------------------------------------------------------
  // Active while run bit is high in pulse mode, polarity optional
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= 1'b0;
    end else if (pulse_mode) begin
      out_q <= counter_run_bit ^ ctrl_q.invert;
    end else begin
      out_q <= 1'b0;
    end
  end
  assign pulse_out = out_q;
  assign pulse_oe  = pulse_mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Counter start and hold
  chk_run_rise_zero: assert property (@(posedge clk) disable iff (!resetn)
    run_rise |=> count_q == 10'h000)
    else $error("counter not restarted on run rise");
  chk_hold_stopped: assert property (@(posedge clk) disable iff (!resetn)
    (!counter_run_bit && !run_rise) |=> $stable(count_q) || run_rise)
    else $error("counter moved while stopped");

  // Single pulse
  chk_match_clears_run: assert property (@(posedge clk) disable iff (!resetn)
    ev_a |=> !counter_run_bit)
    else $error("compare A did not clear run bit");
  chk_pulse_irq: assert property (@(posedge clk) disable iff (!resetn)
    ev_a |=> timer_irq)
    else $error("no request on compare A match");
  chk_pulse_level: assert property (@(posedge clk) disable iff (!resetn)
    pulse_mode |=> pulse_out == ($past(counter_run_bit) ^ $past(ctrl_q.invert)))
    else $error("pulse level wrong");
  chk_trail_edge: assert property (@(posedge clk) disable iff (!resetn)
    pulse_mode && run_fall |=> pulse_out == $past(ctrl_q.invert))
    else $error("pulse did not end on run clear");
  chk_pulse_counts: assert property (@(posedge clk) disable iff (!resetn)
    pulse_mode && counter_run_bit && !run_rise |=> count_q == $past(count_q) + 10'h001)
    else $error("pulse counter did not advance");
  chk_trig_starts: assert property (@(posedge clk) disable iff (!resetn)
    pulse_mode && trig_hit && !counter_run_bit |=> counter_run_bit)
    else $error("trigger did not set run bit");

  // Capture
  chk_capture_copy: assert property (@(posedge clk) disable iff (!resetn)
    ev_c |=> compare_a_value == $past(count_q))
    else $error("capture did not latch count");
  chk_status_set: assert property (@(posedge clk) disable iff (!resetn)
    ev_c |=> stat_q[`STAT_CAPTURE])
    else $error("capture flag not set");
  chk_period_wrap: assert property (@(posedge clk) disable iff (!resetn)
    ev_p && !run_rise |=> count_q == 10'h000)
    else $error("period match did not clear counter");
  chk_capt_runs: assert property (@(posedge clk) disable iff (!resetn)
    capt_mode && counter_run_bit && !run_rise |=> count_q != $past(count_q))
    else $error("capture counter stalled");
  chk_capt_disabled: assert property (@(posedge clk) disable iff (!resetn)
    capt_mode && ctrl_q.pin_func == 2'h3 && !wr_en |=> $stable(compare_a_value))
    else $error("capture taken while disabled");
  chk_no_out_capt: assert property (@(posedge clk) disable iff (!resetn)
    capt_mode |-> !pulse_oe ##1 !pulse_out)
    else $error("output driven in capture");

  // Bus and request strobe
  chk_bad_write: assert property (@(posedge clk) disable iff (!resetn)
    psel && penable && pwrite && !mapped |=> $stable(ctrl_q) && $stable(period_compare_value))
    else $error("unmapped write changed a register");
  chk_no_spurious_irq: assert property (@(posedge clk) disable iff (!resetn)
    !(ev_a || ev_p || ev_c) |=> !timer_irq)
    else $error("request without an event");

  cov_pulse: cover property (@(posedge clk) disable iff (!resetn) ev_a);
  cov_capture: cover property (@(posedge clk) disable iff (!resetn) ev_c);
  cov_wrap: cover property (@(posedge clk) disable iff (!resetn) ev_p);
  cov_trig: cover property (@(posedge clk) disable iff (!resetn) pulse_mode && trig_hit);
  cov_full_scale: cover property (@(posedge clk) disable iff (!resetn)
    capt_mode && count_q == 10'h3FF);
endmodule
`default_nettype wire

// [pin_model.sv]
// Pin-side model: trigger and capture input levels seen by the timer
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // Clock
  input  wire logic clk,
  // Pin levels toward the timer
  output var logic  ext_trigger_pin,
  output var logic  capture_pin_zero,
  output var logic  capture_pin_one
);
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // All pins rest low until a scenario moves them
  initial begin
    ext_trigger_pin  = 1'b0;
    capture_pin_zero = 1'b0;
    capture_pin_one  = 1'b0;
  end

  // Move one pin just after a rising edge, so it is synchronous to the timer clock
  task automatic drive(input int idx, input logic v);
    @(posedge clk);
    case (idx)
      0: ext_trigger_pin <= v;
      1: capture_pin_zero <= v;
      default: capture_pin_one <= v;
    endcase
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the single-pulse and capture timer
`timescale 1ns/1ps
`default_nettype none
`include "stm_cfg.svh"
module testbench
  import stm_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk, resetn, psel, penable, pwrite, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, c1;
  logic        pready, pslverr, pulse_out, pulse_oe, timer_irq, trig, cap0, cap1;
  int          err_total, samples_checked, irq_cnt, w;

  stm_timer dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trigger_pin(trig), .capture_pin_zero(cap0), .capture_pin_one(cap1),
    .pulse_out(pulse_out), .pulse_oe(pulse_oe), .timer_irq(timer_irq));
  pin_model pins (.clk(clk), .ext_trigger_pin(trig), .capture_pin_zero(cap0),
    .capture_pin_one(cap1));

  // Clock of 40 ns period
  always #20 clk = ~clk;
  // Count event strobes
  always @(posedge clk) if (timer_irq === 1'b1) irq_cnt++;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] inr(logic [31:0] v, logic [31:0] lo, logic [31:0] hi);
    return {31'h0, (v >= lo) && (v <= hi)};
  endfunction

  // One APB transfer: setup, then access held until pready at a rising edge
  task automatic xfer(input logic [11:0] a, input logic wn, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wn; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin err_total++; $display("unexpected pready wait: expected 1 seen 0"); results(); end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d); xfer(a, 1'b1, d); endtask
  task automatic rd(input logic [11:0] a); xfer(a, 1'b0, 32'h0); endtask

  // Bounded wait for a pulse level
  task automatic wait_pulse(input logic v, input int lim);
    int n;
    n = 0;
    while (pulse_out !== v && n < lim) begin @(posedge clk); n++; end
    if (n >= lim) begin err_total++; $display("unexpected pulse wait: expected %b seen %b", v, pulse_out); results(); end
  endtask

  // Cycles spent at a level, bounded
  task automatic width(input logic v, output int n);
    n = 0;
    while (pulse_out === v && n < 1100) begin @(posedge clk); n++; end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values and unmapped access
  task automatic sc_reset();
    wr(12'h014, 32'hFFFF_FFFF); chk("unmapped write err", {31'h0, re}, 32'h1);
    rd(`OFF_CTRL);   chk("ctrl reset", rv, `CTRL_RST);
    rd(`OFF_CMPA);   chk("cmpa reset", rv, 32'h0);
    rd(`OFF_PERIOD); chk("period reset", rv, 32'h0);
    rd(`OFF_COUNT);  chk("count reset", rv, 32'h0);
    rd(12'h014);     chk("unmapped err", {31'h0, re}, 32'h1);
    chk("unmapped data", rv, 32'h0);
  endtask

  // Software start, compare A end, period/clear/swap set but ignored
  task automatic sc_pulse_sw();
    wr(`OFF_PERIOD, 32'h1);
    wr(`OFF_CMPA, 32'h0C8);
    irq_cnt = 0;
    wr(`OFF_CTRL, 32'h0000_019D);
    wait_pulse(1'b1, 5);
    chk("pulse oe", {31'h0, pulse_oe}, 32'h1);
    width(1'b1, w);
    chk("pulse width", inr(w, 199, 202), 32'h1);
    rd(`OFF_CTRL);  chk("run cleared", {31'h0, rv[0]}, 32'h0);
    rd(`OFF_COUNT); c1 = rv;
    rd(`OFF_COUNT); chk("count held", rv, c1);
    rd(`OFF_STATUS); chk("cmpa flag", {31'h0, rv[0]}, 32'h1);
    chk("pulse irq", irq_cnt, 32'h1);
    wr(`OFF_STATUS, 32'h7);
  endtask

  // Software clear ends the pulse early, no compare event
  task automatic sc_pulse_abort();
    wr(`OFF_CMPA, 32'h1F4);
    irq_cnt = 0;
    wr(`OFF_CTRL, 32'h0000_001D);
    wait_pulse(1'b1, 5);
    repeat (30) @(posedge clk);
    wr(`OFF_CTRL, 32'h0000_001C);
    wait_pulse(1'b0, 4);
    rd(`OFF_COUNT); c1 = rv;
    repeat (10) @(posedge clk);
    rd(`OFF_COUNT); chk("count frozen", rv, c1);
    chk("abort irq", irq_cnt, 32'h0);
  endtask

  // Trigger pin starts inverted pulses twice; counter restarts from zero
  task automatic sc_pulse_trig();
    wr(`OFF_CMPA, 32'h00A);
    wr(`OFF_CTRL, 32'h0000_005C);
    repeat (3) @(posedge clk);
    chk("idle inverted", {31'h0, pulse_out}, 32'h1);
    repeat (2) begin
      pins.drive(0, 1'b1);
      wait_pulse(1'b0, 8);
      width(1'b0, w);
      chk("trig width", inr(w, 9, 12), 32'h1);
      rd(`OFF_CTRL); chk("trig run clear", {31'h0, rv[0]}, 32'h0);
      pins.drive(0, 1'b0);
    end
    // Falling trigger edge selected: a rise is ignored, a fall starts the pulse
    wr(`OFF_CTRL, 32'h0000_045C);
    pins.drive(0, 1'b1);
    repeat (4) @(posedge clk);
    chk("rise ignored", {31'h0, pulse_out}, 32'h1);
    pins.drive(0, 1'b0);
    wait_pulse(1'b0, 8);
    width(1'b0, w);
    chk("fall trig width", inr(w, 9, 12), 32'h1);
  endtask

  // Every edge code on both pins, the other pin toggling as noise
  task automatic sc_capture();
    logic er, ef;
    for (int sel = 0; sel < 2; sel++) begin
      for (int code = 0; code < 4; code++) begin
        er = (code == 0) || (code == 2);
        ef = (code == 1) || (code == 2);
        wr(`OFF_CTRL, 32'h0);
        wr(`OFF_STATUS, 32'h7);
        wr(`OFF_CMPA, 32'h3FF);
        wr(`OFF_CTRL, {21'h0, 1'b0, sel[0], 4'h0, code[1:0], 2'b01, 1'b1});
        repeat (40) @(posedge clk);
        pins.drive(2 - sel, 1'b1);
        pins.drive(2 - sel, 1'b0);
        pins.drive(1 + sel, 1'b1);
        repeat (4) @(posedge clk);
        chk("capture oe", {31'h0, pulse_oe}, 32'h0);
        rd(`OFF_STATUS); chk("rise capture", {31'h0, rv[2]}, {31'h0, er});
        rd(`OFF_CMPA);
        chk("captured count", er ? inr(rv, 40, 60) : rv, er ? 32'h1 : 32'h3FF);
        wr(`OFF_STATUS, 32'h4);
        pins.drive(1 + sel, 1'b0);
        repeat (4) @(posedge clk);
        rd(`OFF_STATUS); chk("fall capture", {31'h0, rv[2]}, {31'h0, ef});
      end
    end
  endtask

  // Period match wraps the count; zero period runs to full scale
  task automatic sc_period();
    wr(`OFF_CTRL, 32'h0);
    wr(`OFF_PERIOD, 32'h1);
    irq_cnt = 0;
    wr(`OFF_CTRL, 32'h0000_001B);
    repeat (448) @(posedge clk);
    chk("period irqs", irq_cnt, 32'h3);
    rd(`OFF_COUNT); chk("wrapped count", inr(rv, 0, 127), 32'h1);
    rd(`OFF_STATUS); chk("period flag", {31'h0, rv[1]}, 32'h1);
    wr(`OFF_CTRL, 32'h0);
    wr(`OFF_PERIOD, 32'h0);
    irq_cnt = 0;
    wr(`OFF_CTRL, 32'h0000_001B);
    repeat (600) @(posedge clk);
    rd(`OFF_COUNT); chk("full count", inr(rv, 600, 615), 32'h1);
    chk("no wrap irq", irq_cnt, 32'h0);
    repeat (500) @(posedge clk);
    rd(`OFF_COUNT); chk("wrapped full", inr(rv, 60, 100), 32'h1);
    wr(`OFF_CTRL, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0; resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; err_total = 0; samples_checked = 0; irq_cnt = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    sc_reset();
    sc_pulse_sw();
    sc_pulse_abort();
    sc_pulse_trig();
    sc_capture();
    sc_period();
    results();
  end
endmodule
`default_nettype wire
